/* src/spm_defs.svh */
// Purpose: Constants for the sleep/active power mode controller.
// Assumes: Clock mclk at 250 MHz; times given in their own units.
// Notes:   Cycle counts are derived from the times and the clock rate.
`ifndef SPM_DEFS_SVH
`define SPM_DEFS_SVH

`define SPM_MCLK_MHZ      250
`define SPM_GRACE_US      1000
`define SPM_RELEASE_US    500
`define SPM_RST_STUCK_US  2000
`define SPM_FILT_NS       1000
`define SPM_GRACE_CYC     (`SPM_GRACE_US * `SPM_MCLK_MHZ)
`define SPM_RELEASE_CYC   (`SPM_RELEASE_US * `SPM_MCLK_MHZ)
`define SPM_RST_STUCK_CYC (`SPM_RST_STUCK_US * `SPM_MCLK_MHZ)
`define SPM_FILT_CYC      ((`SPM_FILT_NS * `SPM_MCLK_MHZ + 999) / 1000)

`define SPM_CH_LIN        0
`define SPM_CH_STATUS     1
`define SPM_CH_NET        2
`define SPM_CH_SWITCH     3
`define SPM_CH_PULSE      4
`define SPM_CH_KEEP       5
`define SPM_CH_RSTLOW     6
`define SPM_CH_RGN0       7
`define SPM_CH_RGN1       8
`define SPM_CH_APPOK      9
`define SPM_CH_FLOOR      10
`define SPM_NUM_CH        11

`define SPM_RGN_LOW       2'h0
`define SPM_RGN_CRIT      2'h1
`define SPM_RGN_NORMAL    2'h2
`define SPM_RGN_SUPER     2'h3

`endif

/* src/spm_pkg.sv */
// Purpose: Types shared by the power mode controller.
// Assumes: Nothing beyond the constants header.
// Notes:   State codes are left to the tools.
package spm_pkg;
  typedef enum logic [1:0] {SPM_INIT, SPM_SLEEP, SPM_ACTIVE} spm_state_t;
endpackage

/* src/spm_qual_if.sv */
// Purpose: Carries raw and qualified activity levels between the filter and the controller.
// Assumes: All levels are active high on both sides.
// Notes:   settled rises once every channel has had one full filter period.
interface spm_qual_if #(parameter int N = 11);
  logic [N-1:0] raw;
  logic [N-1:0] qual;
  logic         settled;
  modport filt (input raw, output qual, output settled);
  modport user (output raw, input qual, input settled);
endinterface

/* src/spm_glitch_filter.sv */
// Purpose: Synchronises and glitch-filters every activity and sense input.
// Assumes: Raw inputs are asynchronous to mclk.
// Notes:   A level is passed on only after holding for FILT_CYC cycles.
`include "spm_defs.svh"

module spm_glitch_filter
  import spm_pkg::*;
#(
  parameter int N        = `SPM_NUM_CH,
  parameter int FILT_CYC = `SPM_FILT_CYC
)
(
  input  wire logic mclk,          // System clock.
  input  wire logic rstn,          // Asynchronous reset, active low.
  spm_qual_if.filt  q              // Raw in, qualified out.
);
  localparam int CW = $clog2(FILT_CYC + 4);
  localparam logic [CW-1:0] LOAD = CW'(FILT_CYC);
  localparam logic [CW-1:0] SETTLE = CW'(FILT_CYC + 3);

  logic [CW-1:0] settle_r;
  logic          settled_r;

  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_ch
      logic          s1_r;
      logic          s2_r;
      logic          s3_r;
      logic          qual_r;
      logic [CW-1:0] cnt_r;
      wire           agree = (s2_r == s3_r);
      always_ff @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
        begin
          s1_r   <= 1'b0;
          s2_r   <= 1'b0;
          s3_r   <= 1'b0;
          cnt_r  <= LOAD;
          qual_r <= 1'b0;
        end
        else
        begin
          s1_r <= q.raw[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          // A pulse shorter than the filter period restarts the count.
          if (!agree)
            cnt_r <= LOAD;
          else if (cnt_r != '0)
            cnt_r <= cnt_r - 1'b1;
          else
            qual_r <= s3_r;
        end
      end
      assign q.qual[i] = qual_r;
    end
  endgenerate

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      settle_r  <= SETTLE;
      settled_r <= 1'b0;
    end
    else if (settle_r != '0)
      settle_r <= settle_r - 1'b1;
    else
      settled_r <= 1'b1;
  end

  assign q.settled = settled_r;
endmodule

/* src/spm_power_mode.sv */
// Purpose: Sleep/active mode controller driving the regulator enable.
// Assumes: Battery region code and supply-valid level come from comparators.
// Notes:   All timers run on mclk; long counts are parameters for simulation.
`include "spm_defs.svh"

module spm_power_mode
  import spm_pkg::*;
#(
  parameter int GRACE_CYC     = `SPM_GRACE_CYC,
  parameter int RELEASE_CYC   = `SPM_RELEASE_CYC,
  parameter int RST_STUCK_CYC = `SPM_RST_STUCK_CYC,
  parameter int FILT_CYC      = `SPM_FILT_CYC
)
(
  input  wire logic       mclk,                    // System clock.
  input  wire logic       rstn,                    // Asynchronous reset.
  input  wire logic       lin_wake_n,              // LIN pin level.
  input  wire logic       status_wake_n,           // Status wake input.
  input  wire logic       network_rx_pair,         // Network rx activity.
  input  wire logic       local_switch_wake_n,     // Local switch input.
  input  wire logic       supply_pulse_event,      // Supply pulse seen.
  input  wire logic       supply_pulse_en,         // Pulse wake enable.
  input  wire logic [1:0] battery_sense_input,     // Battery region code.
  input  wire logic       app_supply_sense,        // App supply valid.
  input  wire logic       keep_awake_n,            // Keep-awake pin.
  input  wire logic       hold_bit,                // Software hold.
  input  wire logic       wake_allow_super_bit,    // Wake in super.
  input  wire logic       crit_wr,                 // Write critical bit.
  input  wire logic       crit_wr_data,            // New critical bit.
  input  wire logic       wake_floor_config_pin,   // Power-up strap.
  input  wire logic [3:0] override_set,            // Set override bits.
  input  wire logic       reset_pin_i,             // Reset pin level.
  output logic            reset_pin_o,             // Reset pin drive value.
  output logic            reset_pin_oe,            // Reset pin enable.
  output logic            regulator_en_o,          // Enable drive value.
  output logic            regulator_en_oe,         // Enable pin enable.
  output logic            active_mode,             // Active mode flag.
  output logic            circuits_en,             // Non-critical power.
  output logic            wake_allow_critical_bit, // Critical wake bit.
  output logic [3:0]      override_bits,           // Override bits.
  output logic [4:0]      wake_source              // Sources of last wake.
);
  localparam int GW = $clog2(GRACE_CYC + 1);
  localparam int RW = $clog2(RELEASE_CYC + 1);
  localparam int SW = $clog2(RST_STUCK_CYC + 1);
  localparam logic [GW-1:0] GRACE_LD   = GW'(GRACE_CYC);
  localparam logic [RW-1:0] RELEASE_LD = RW'(RELEASE_CYC);
  localparam logic [SW-1:0] STUCK_LD   = SW'(RST_STUCK_CYC);

  spm_qual_if #(.N(`SPM_NUM_CH)) qi ();

  spm_glitch_filter #(
    .N        (`SPM_NUM_CH),
    .FILT_CYC (FILT_CYC)
  ) u_filt (
    .mclk (mclk),
    .rstn (rstn),
    .q    (qi.filt)
  );

  // Raw levels are turned active high before filtering.
  assign qi.raw[`SPM_CH_LIN]    = ~lin_wake_n;
  assign qi.raw[`SPM_CH_STATUS] = ~status_wake_n;
  assign qi.raw[`SPM_CH_NET]    = network_rx_pair;
  assign qi.raw[`SPM_CH_SWITCH] = ~local_switch_wake_n;
  assign qi.raw[`SPM_CH_PULSE]  = supply_pulse_event;
  assign qi.raw[`SPM_CH_KEEP]   = ~keep_awake_n;
  assign qi.raw[`SPM_CH_RSTLOW] = ~reset_pin_i;
  assign qi.raw[`SPM_CH_RGN0]   = battery_sense_input[0];
  assign qi.raw[`SPM_CH_RGN1]   = battery_sense_input[1];
  assign qi.raw[`SPM_CH_APPOK]  = app_supply_sense;
  assign qi.raw[`SPM_CH_FLOOR]  = wake_floor_config_pin;

  spm_state_t     state_r;
  spm_state_t     state_nxt;
  logic           crit_r;
  logic [3:0]     ovr_r;
  logic [3:0]     ovr_nxt;
  logic [4:0]     src_r;
  logic [GW-1:0]  grace_r;
  logic [GW-1:0]  min_act_r;
  logic [RW-1:0]  release_r;
  logic [SW-1:0]  stuck_r;
  logic [GW-1:0]  rst_rise_r;
  logic           rst_low_d_r;
  logic           reg_oe_r;
  logic           rst_oe_r;

  // Filtered levels.
  wire [1:0] region   = {qi.qual[`SPM_CH_RGN1], qi.qual[`SPM_CH_RGN0]};
  wire       keep_pin = qi.qual[`SPM_CH_KEEP];
  wire       rst_low  = qi.qual[`SPM_CH_RSTLOW];
  wire       app_ok   = qi.qual[`SPM_CH_APPOK];
  wire       floor_hi = qi.qual[`SPM_CH_FLOOR];
  wire       in_low   = (region == `SPM_RGN_LOW);

  // Allowed wake range: normal always, low never.
  function automatic logic range_ok(input logic [1:0] rg, input logic crit_blk);
    logic ok;
    ok = 1'b0;
    unique case (rg)
      `SPM_RGN_LOW:    ok = 1'b0;
      `SPM_RGN_CRIT:   ok = ~crit_blk;
      `SPM_RGN_NORMAL: ok = 1'b1;
      `SPM_RGN_SUPER:  ok = wake_allow_super_bit;
    endcase
    return ok;
  endfunction

  // A set bit forbids critical-region wake; the strap picks the default.
  wire wake_ok      = range_ok(region, crit_r);
  wire powerup_ok   = range_ok(region, floor_hi);

  // Pin sources and network activity after override masking.
  wire [3:0] pin_act   = qi.qual[3:0];
  wire [3:0] masked    = pin_act & ~ovr_r;
  wire       pulse_act = qi.qual[`SPM_CH_PULSE] & supply_pulse_en;
  wire [4:0] wake_vec  = {pulse_act, masked};
  wire       activity  = |wake_vec;

  // Hold bit counts as keep-awake low; both lost on invalid supply.
  wire keep_req     = (keep_pin | hold_bit) & app_ok;
  wire act_clear    = ~activity | in_low;
  wire release_done = (release_r == '0) | in_low;
  wire grace_done   = (grace_r == '0);
  wire min_done     = (min_act_r == '0);
  wire reset_done   = (stuck_r == '0) & (rst_rise_r == '0);
  wire rst_fall     = rst_low & ~rst_low_d_r;
  wire rst_rise     = ~rst_low & rst_low_d_r;

  // All six sleep conditions together; the wake range is not consulted.
  wire go_sleep = act_clear & ~keep_req & release_done & grace_done
                & min_done & reset_done;
  wire go_wake  = activity & wake_ok;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      SPM_INIT:
      begin
        // Wait for filtered levels before judging the battery.
        if (qi.settled)
          state_nxt = powerup_ok ? SPM_ACTIVE : SPM_SLEEP;
      end
      SPM_SLEEP:
      begin
        if (go_wake)
          state_nxt = SPM_ACTIVE;
      end
      SPM_ACTIVE:
      begin
        if (go_sleep)
          state_nxt = SPM_SLEEP;
      end
      default:
        state_nxt = SPM_INIT;
    endcase
  end

  wire enter_active = (state_nxt == SPM_ACTIVE) & (state_r != SPM_ACTIVE);
  wire is_active    = (state_r == SPM_ACTIVE);

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      state_r <= SPM_INIT;
    else
      state_r <= state_nxt;
  end

  // Enable pin is driven low only in Active mode, else floated.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      reg_oe_r <= 1'b0;
    else
      reg_oe_r <= (state_nxt == SPM_ACTIVE);
  end

  // Strap caught once filters have settled; later writes come from software.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      crit_r <= 1'b0;
    else if (state_r == SPM_INIT && qi.settled)
      crit_r <= floor_hi;
    else if (crit_wr)
      crit_r <= crit_wr_data;
  end

  // Set wins over the automatic clear so a set is never lost.
  genvar b;
  generate
    for (b = 0; b < 4; b++)
    begin : g_ovr
      assign ovr_nxt[b] = override_set[b] | (ovr_r[b] & pin_act[b]);
    end
  endgenerate

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      ovr_r <= 4'h0;
    else
      ovr_r <= ovr_nxt;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      src_r <= 5'h00;
    else if (enter_active && state_r == SPM_SLEEP)
      src_r <= wake_vec;
  end

  // Grace timer restarts on entry and while the host holds power.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      grace_r <= GRACE_LD;
    else if (enter_active || (is_active && keep_req))
      grace_r <= GRACE_LD;
    else if (is_active && grace_r != '0)
      grace_r <= grace_r - 1'b1;
  end

  // Minimum time since the enable went low; never restarted by the host.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      min_act_r <= GRACE_LD;
    else if (enter_active)
      min_act_r <= GRACE_LD;
    else if (is_active && min_act_r != '0)
      min_act_r <= min_act_r - 1'b1;
  end

  // Release delay runs only while nothing asks to stay awake.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      release_r <= RELEASE_LD;
    else if (keep_req || enter_active)
      release_r <= RELEASE_LD;
    else if (release_r != '0)
      release_r <= release_r - 1'b1;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rst_low_d_r <= 1'b0;
    else
      rst_low_d_r <= rst_low;
  end

  // A reset held low past the timeout is taken as stuck and stops blocking.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      stuck_r <= '0;
    else if (rst_fall)
      stuck_r <= STUCK_LD;
    else if (stuck_r != '0)
      stuck_r <= stuck_r - 1'b1;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rst_rise_r <= '0;
    else if (rst_rise)
      rst_rise_r <= GRACE_LD;
    else if (rst_rise_r != '0)
      rst_rise_r <= rst_rise_r - 1'b1;
  end

  // Reset generator pulls the pin low while the app supply is invalid.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rst_oe_r <= 1'b0;
    else
      rst_oe_r <= ~app_ok & qi.settled;
  end

  assign reset_pin_o             = 1'b0;
  assign reset_pin_oe            = rst_oe_r;
  assign regulator_en_o          = 1'b0;
  assign regulator_en_oe         = reg_oe_r;
  assign active_mode             = reg_oe_r;
  assign circuits_en             = reg_oe_r;
  assign wake_allow_critical_bit = crit_r;
  assign override_bits           = ovr_r;
  assign wake_source             = src_r;
endmodule

/* verification/spm_checker.sv */
// Purpose: Port-level assertions for the power mode controller.
// Assumes: Bound to spm_power_mode; counters watch the raw inputs and active_mode.
// Notes:   Raw inputs lead their filtered copies, so every bound is safe.
module spm_checker
  import spm_pkg::*;
#(
  parameter int GRACE_CYC     = 20,
  parameter int RELEASE_CYC   = 10,
  parameter int RST_STUCK_CYC = 40
)
(
  input wire logic       mclk,                    // Clock.
  input wire logic       rstn,                    // Reset, active low.
  input wire logic [1:0] battery_sense_input,     // Battery region.
  input wire logic       app_supply_sense,        // App supply valid.
  input wire logic       keep_awake_n,            // Keep-awake pin.
  input wire logic       hold_bit,                // Software hold.
  input wire logic       crit_wr,                 // Critical bit write.
  input wire logic       crit_wr_data,            // Critical bit value.
  input wire logic [3:0] override_set,            // Override set pulses.
  input wire logic       reset_pin_i,             // Reset pin level.
  input wire logic       reset_pin_o,             // Reset drive value.
  input wire logic       regulator_en_o,          // Enable drive value.
  input wire logic       regulator_en_oe,         // Enable pin enable.
  input wire logic       active_mode,             // Active flag.
  input wire logic       circuits_en,             // Non-critical power.
  input wire logic       wake_allow_critical_bit, // Critical wake bit.
  input wire logic [3:0] override_bits,           // Override bits.
  input wire logic       reset_pin_oe             // Reset pin enable.
);
  logic [15:0] low_cnt, keep_cnt, rel_cnt, rst_cnt, on_cnt;
  wire logic   keep_req;
  assign keep_req = (!keep_awake_n || hold_bit) && app_supply_sense;
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
    begin
      low_cnt  <= 16'h0;
      keep_cnt <= 16'h0;
      rel_cnt  <= 16'h0;
      rst_cnt  <= 16'h0;
      on_cnt   <= 16'h0;
    end
    else
    begin
      low_cnt  <= (battery_sense_input == 2'h0) ? low_cnt + 16'h1 : 16'h0;
      keep_cnt <= keep_req ? keep_cnt + 16'h1 : 16'h0;
      rel_cnt  <= keep_req ? 16'h0 : rel_cnt + 16'h1;
      rst_cnt  <= reset_pin_i ? 16'h0 : rst_cnt + 16'h1;
      on_cnt   <= active_mode ? on_cnt + 16'h1 : 16'h0;
    end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_drive_zero: assert property (regulator_en_o == 1'h0 && reset_pin_o == 1'h0)
    else $error("drive value of an open-drain pin is not zero");
  a_mode_outputs: assert property (regulator_en_oe == active_mode && circuits_en == active_mode)
    else $error("enable or circuit power differs from mode");
  a_no_low_wake: assert property (low_cnt >= 12 |-> !$rose(active_mode))
    else $error("woke while battery in low region");
  a_min_active: assert property ($fell(active_mode) |-> on_cnt >= GRACE_CYC)
    else $error("left active before grace time");
  a_keep_blocks: assert property (keep_cnt >= 12 |-> !$fell(active_mode))
    else $error("slept while keep-awake or hold asserted");
  a_release_wait: assert property ($fell(active_mode) && battery_sense_input != 2'h0 |-> rel_cnt >= RELEASE_CYC)
    else $error("slept before release delay");
  a_reset_stuck: assert property ($fell(active_mode) && !reset_pin_i |-> rst_cnt >= RST_STUCK_CYC)
    else $error("slept before stuck reset timeout");
  a_override_set: assert property (|override_set |=> (override_bits & $past(override_set)) == $past(override_set))
    else $error("override bit not set");
  a_crit_write: assert property (crit_wr |=> wake_allow_critical_bit == $past(crit_wr_data))
    else $error("critical bit write lost");
  c_wake: cover property ($rose(active_mode));
  c_sleep: cover property ($fell(active_mode));
  c_override: cover property (|override_bits);
  c_reset: cover property (reset_pin_oe);
endmodule

/* verification/spm_host_model.sv */
// Purpose: Behavioural external host that holds the keep-awake input.
// Assumes: The host is powered only while the controller is active.
// Notes:   A released keep-awake line reads high through its pull-up.
module spm_host_model
(
  input  wire logic mclk,         // Clock.
  input  wire logic rstn,         // Reset, active low.
  input  wire logic active_mode,  // Host power on.
  input  wire logic want_power,   // Host still busy.
  output logic      keep_awake_n  // Keep-awake drive.
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
      keep_awake_n <= 1'h1;
    else
      keep_awake_n <= !(active_mode && want_power);
endmodule

/* verification/tb_top.sv */
// Purpose: Self-checking bench for the power mode controller.
// Assumes: Small timer values; the host model drives keep-awake.
// Notes:   Activity is held far longer than the filter so it always counts.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import spm_pkg::*;
  localparam int GR = 20;
  localparam int RL = 10;
  typedef struct packed {logic [4:0] act; logic [1:0] rgn; logic sup; logic crit; logic wake;} spm_row_t;
  logic mclk = 1'h0, rstn = 1'h0, lin_wake_n = 1'h1, status_wake_n = 1'h1, network_rx_pair = 1'h0;
  logic local_switch_wake_n = 1'h1, supply_pulse_event = 1'h0, supply_pulse_en = 1'h1;
  logic app_supply_sense = 1'h1, hold_bit = 1'h0, wake_allow_super_bit = 1'h0, crit_wr = 1'h0;
  logic crit_wr_data = 1'h0, wake_floor_config_pin = 1'h0, want_power = 1'h0, ext_rst = 1'h0;
  logic [1:0] battery_sense_input = 2'h2;
  logic [3:0] override_set = 4'h0, override_bits;
  logic [4:0] wake_source;
  logic keep_awake_n, reset_pin_i, reset_pin_o, reset_pin_oe, regulator_en_o, regulator_en_oe;
  logic active_mode, circuits_en, wake_allow_critical_bit;
  int err_count = 0, total_checks = 0, cyc = 0, n;
  spm_row_t rows [10] = '{'{5'h01, 2'h2, 1'h0, 1'h0, 1'h1}, '{5'h02, 2'h2, 1'h0, 1'h0, 1'h1},
    '{5'h04, 2'h2, 1'h0, 1'h0, 1'h1}, '{5'h08, 2'h2, 1'h0, 1'h0, 1'h1}, '{5'h10, 2'h2, 1'h0, 1'h0, 1'h1},
    '{5'h01, 2'h0, 1'h1, 1'h0, 1'h0}, '{5'h01, 2'h3, 1'h0, 1'h0, 1'h0}, '{5'h01, 2'h3, 1'h1, 1'h0, 1'h1},
    '{5'h01, 2'h1, 1'h0, 1'h0, 1'h1}, '{5'h01, 2'h1, 1'h0, 1'h1, 1'h0}};
  // The reset pin is open drain with a pull-up: low if either party pulls it.
  assign reset_pin_i = !(reset_pin_oe || ext_rst);
  spm_power_mode #(.GRACE_CYC(GR), .RELEASE_CYC(RL), .RST_STUCK_CYC(40), .FILT_CYC(3)) DUT (
    .mclk, .rstn, .lin_wake_n, .status_wake_n, .network_rx_pair, .local_switch_wake_n,
    .supply_pulse_event, .supply_pulse_en, .battery_sense_input, .app_supply_sense, .keep_awake_n,
    .hold_bit, .wake_allow_super_bit, .crit_wr, .crit_wr_data, .wake_floor_config_pin, .override_set,
    .reset_pin_i, .reset_pin_o, .reset_pin_oe, .regulator_en_o, .regulator_en_oe, .active_mode,
    .circuits_en, .wake_allow_critical_bit, .override_bits, .wake_source);
  spm_host_model u_host (.mclk, .rstn, .active_mode, .want_power, .keep_awake_n);
  always #2 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      end_sim();
    end
  end
  task end_sim;
    if (err_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task check(input logic [4:0] seen, input logic [4:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task cyc_wait(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  // Bounded wait for a mode; n holds the cycles spent.
  task wait_act(input logic v, input int lim);
    n = 0;
    while (active_mode !== v && n < lim)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask
  task set_act(input logic [4:0] a);
    @(posedge mclk);
    lin_wake_n <= !a[0];
    status_wake_n <= !a[1];
    network_rx_pair <= a[2];
    local_switch_wake_n <= !a[3];
    supply_pulse_event <= a[4];
  endtask
  task wake_lin;
    set_act(5'h01);
    wait_act(1'h1, 40);
    set_act(5'h00);
  endtask
  initial
  begin
    repeat (12) @(posedge mclk);
    rstn <= 1'h1;
    wait_act(1'h1, 30);
    check(5'(regulator_en_oe), 5'h1);
    check(5'(regulator_en_o), 5'h0);
    check(5'(wake_allow_critical_bit), 5'h0);
    wait_act(1'h0, 100);
    check(5'(regulator_en_oe), 5'h0);
    check(5'(circuits_en), 5'h0);
    foreach (rows[i])
    begin
      @(posedge mclk);
      battery_sense_input <= rows[i].rgn;
      wake_allow_super_bit <= rows[i].sup;
      crit_wr <= 1'h1;
      crit_wr_data <= rows[i].crit;
      @(posedge mclk);
      crit_wr <= 1'h0;
      cyc_wait(12);
      set_act(rows[i].act);
      wait_act(1'h1, 40);
      check(5'(active_mode), 5'(rows[i].wake));
      if (rows[i].wake)
        check(wake_source, rows[i].act);
      set_act(5'h00);
      wait_act(1'h0, 200);
      check(5'(active_mode), 5'h0);
    end
    battery_sense_input <= 2'h2;
    want_power <= 1'h1;
    wake_lin();
    cyc_wait(60);
    check(5'(active_mode), 5'h1);
    battery_sense_input <= 2'h3;
    cyc_wait(20);
    check(5'(active_mode), 5'h1);
    hold_bit <= 1'h1;
    want_power <= 1'h0;
    cyc_wait(40);
    check(5'(active_mode), 5'h1);
    hold_bit <= 1'h0;
    wait_act(1'h0, 100);
    check(5'(n >= RL), 5'h1);
    battery_sense_input <= 2'h2;
    want_power <= 1'h1;
    set_act(5'h01);
    cyc_wait(40);
    battery_sense_input <= 2'h0;
    cyc_wait(12);
    want_power <= 1'h0;
    wait_act(1'h0, 100);
    check(5'(active_mode), 5'h0);
    set_act(5'h00);
    cyc_wait(12);
    battery_sense_input <= 2'h2;
    want_power <= 1'h1;
    wake_lin();
    cyc_wait(40);
    app_supply_sense <= 1'h0;
    cyc_wait(12);
    check(5'(reset_pin_oe), 5'h1);
    wait_act(1'h0, 200);
    check(5'(active_mode), 5'h0);
    app_supply_sense <= 1'h1;
    want_power <= 1'h0;
    set_act(5'h01);
    wait_act(1'h1, 40);
    override_set <= 4'h1;
    cyc_wait(1);
    override_set <= 4'h0;
    check(5'(override_bits), 5'h01);
    wait_act(1'h0, 200);
    cyc_wait(30);
    check(5'(active_mode), 5'h0);
    set_act(5'h00);
    cyc_wait(20);
    check(5'(override_bits), 5'h00);
    wake_lin();
    check(5'(active_mode), 5'h1);
    // A reset held low by someone else must keep us awake until the stuck timeout.
    want_power <= 1'h1;
    cyc_wait(12);
    ext_rst <= 1'h1;
    want_power <= 1'h0;
    wait_act(1'h0, 200);
    check(5'(n >= 40), 5'h1);
    check(5'(active_mode), 5'h0);
    ext_rst <= 1'h0;
    cyc_wait(12);
    rstn <= 1'h0;
    wake_floor_config_pin <= 1'h1;
    cyc_wait(3);
    rstn <= 1'h1;
    cyc_wait(15);
    check(5'(wake_allow_critical_bit), 5'h1);
    check(5'(active_mode), 5'h1);
    end_sim();
  end
endmodule
bind spm_power_mode spm_checker #(.GRACE_CYC(GRACE_CYC), .RELEASE_CYC(RELEASE_CYC),
  .RST_STUCK_CYC(RST_STUCK_CYC)) u_chk (.mclk, .rstn, .battery_sense_input, .app_supply_sense,
  .keep_awake_n, .hold_bit, .crit_wr, .crit_wr_data, .override_set, .reset_pin_i, .reset_pin_o,
  .regulator_en_o, .regulator_en_oe, .active_mode, .circuits_en, .wake_allow_critical_bit,
  .override_bits, .reset_pin_oe);
